// >>> design/sdp_segment_protection.sv
// segment descriptor cache and protection checks behind an axi4-lite slave
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.

// What this block does
// [RULE1] descriptors are eight bytes: base, limit, granularity, privilege, rights, type
// [RULE2] access to a segment whose present bit is clear faults with vector 11
// [RULE3] segment privilege level sits in access byte bits 6:5, levels 0 to 3
// [RULE4] access byte bit 4 set means code or data, clear means system
// [RULE5] physical address is base plus offset cut to 24 bits
// [RULE6] data segments check grow-up or grow-down limits; writes need writable flag
// [RULE7] conforming code runs when current level >= segment level; reads need readable
// [RULE8] accessed bit is set on segment load or selector test
// [RULE9] granularity flag scales the 20-bit limit by bytes or 4-Kbyte units
// [RULE10] descriptor base bits 31:24 have no effect, except in a local table descriptor, whose full 32-bit base is kept
// [RULE11] only system types 2,5,9,B,C,E,F accepted, with 32-bit base
// [RULE12] selector splits into table select bit, 8K index and requestor field
// [RULE13] segment register write fetches its descriptor into the hidden cache
// [RULE14] cache changes only on segment register write; software reloads after edits
// [RULE15] data of level p accessible only from level numerically at most p
// [RULE16] code of level p callable only from same or less privileged level
// [RULE17] current level changes only through gate call or its return
// [RULE18] effective level is larger of current level and requestor field
// [RULE19] adjust command raises requestor field to the current level
// [RULE20] port level in flag word bits 14:13, set only at level 0
// [RULE21] port-sensitive instructions above port level fault with vector 13
// [RULE22] requestor field is selector bits 1:0, index is bits 15:3
// [RULE23] data load with effective level beyond segment level faults with 13
// [RULE24] data segment registers accept only data or readable code segments
// [RULE25] failed limit check aborts the access before any bus cycle
module sdp_segment_protection (
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   srst,
  // register bus
  input  wire sdp_pkg::sdp_axil_in_t  axiIn,
  output      sdp_pkg::sdp_axil_out_t axiOut,
  // descriptor table memory
  output      sdp_pkg::sdp_mem_out_t  memOut,
  input  wire sdp_pkg::sdp_mem_in_t   memIn,
  // external access cycle
  output      sdp_pkg::sdp_bus_out_t  busOut
);

  sdp_pkg::sdp_state_t r;
  sdp_pkg::sdp_state_t n;
  logic                cmdFire;
  sdp_pkg::sdp_op_t    cmdOp;
  logic [2:0]          cmdSeg;
  logic [2:0]          segIdx;
  logic                badSeg;
  logic [1:0]          cmdKind;
  logic [2:0]          cmdIo;
  logic [31:0]         wMerged;
  logic                wrOk;
  logic [31:0]         rdWord;
  logic                rdOk;
  logic [63:0]         cd;
  logic [7:0]          ca;
  logic [31:0]         cLim;
  logic [31:0]         cLin;
  logic                cInLim;
  logic                cType;
  logic                cPriv;
  logic                cFault;
  logic [7:0]          cVec;
  logic [63:0]         fd;
  logic [7:0]          fa;
  logic [1:0]          fEpl;
  logic                fGp;
  logic                fFault;
  logic [31:0]         tblBase;
  logic [31:0]         fAddr;

  function automatic logic [1:0] maxPl(input logic [1:0] a, input logic [1:0] b);
    maxPl = (a > b) ? a : b;
  endfunction : maxPl

  // limit in bytes from the 20-bit field
  function automatic logic [31:0] effLimit(input logic [63:0] d);
    effLimit = d[55] ? {d[51:48], d[15:0], sdp_pkg::PAGE_FILL} // RULE9 RULE1
                     : {12'h000, d[51:48], d[15:0]};
  endfunction : effLimit

  // base without bits 31:24
  function automatic logic [23:0] base24(input logic [63:0] d);
    base24 = {d[39:32], d[31:16]}; // RULE10 RULE1
  endfunction : base24

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[8*i +: 8] = dat[8*i +: 8];
      end
    end
  endfunction : merge

  // command word decode
  assign cmdFire = r.awHeld && r.wHeld && (r.awAddr == sdp_pkg::OFF_CMD)
                   && (r.st == sdp_pkg::ST_IDLE);
  assign cmdOp   = sdp_pkg::sdp_op_t'(r.wData[sdp_pkg::CMD_OP_LO +: 3]);
  assign cmdSeg  = r.wData[sdp_pkg::CMD_SEG_LO +: 3];
  assign cmdKind = r.wData[sdp_pkg::CMD_KIND_LO +: 2];
  assign cmdIo   = r.wData[sdp_pkg::CMD_IO_LO +: 3];
  assign badSeg  = cmdSeg >= sdp_pkg::NUM_SEG;
  assign segIdx  = badSeg ? sdp_pkg::SEG_CODE : cmdSeg;
  assign wMerged = merge({16'h0000, r.sel}, r.wData, r.wStrb);

  // access check on the cached descriptor
  assign cd     = r.segDesc[segIdx];
  assign ca     = cd[sdp_pkg::ACC_LO +: 8];
  assign cLim   = effLimit(cd);
  assign cLin   = {8'h00, base24(cd)} + r.offset; // RULE5
  assign cInLim = (!ca[sdp_pkg::ACC_E] && ca[sdp_pkg::ACC_CE]) ? (r.offset > cLim) // RULE6
                                                               : (r.offset <= cLim);
  assign cType  = (cmdKind == sdp_pkg::KIND_WRITE) ?
                    (!ca[sdp_pkg::ACC_E] && ca[sdp_pkg::ACC_WR]) : // RULE6
                  (cmdKind == sdp_pkg::KIND_EXEC) ?
                    (ca[sdp_pkg::ACC_E] && (!ca[sdp_pkg::ACC_CE] || r.current_priv_level >= ca[6:5])) : // RULE7
                    (!ca[sdp_pkg::ACC_E] || ca[sdp_pkg::ACC_WR]); // RULE7
  assign cPriv  = ca[sdp_pkg::ACC_E] || (ca[6:5] >= r.current_priv_level); // RULE15 RULE3
  assign cFault = badSeg || !r.segValid[segIdx] || !ca[sdp_pkg::ACC_P]
                  || !ca[sdp_pkg::ACC_S] || !cType || !cInLim || !cPriv; // RULE25 RULE4
  assign cVec   = (!badSeg && r.segValid[segIdx] && !ca[sdp_pkg::ACC_P]) ?
                  sdp_pkg::VEC_NP : sdp_pkg::VEC_GP; // RULE2

  // table walk address
  assign tblBase = (r.sel[2] && cmdOp != sdp_pkg::OP_LDLOC) ? r.ltBase : r.gtBase; // RULE12
  assign fAddr   = tblBase + {16'h0000, r.sel[15:3], 3'b000}; // RULE22 RULE12

  // checks on a freshly fetched descriptor
  assign fd     = memIn.rdata;
  assign fa     = fd[sdp_pkg::ACC_LO +: 8];
  assign fEpl   = maxPl(r.current_priv_level, r.sel[1:0]); // RULE18 RULE22

  always_comb begin
    fGp = 1'b0;
    if (r.op == sdp_pkg::OP_LDLOC) begin
      fGp = fa[sdp_pkg::ACC_S] || (fa[3:0] != sdp_pkg::TYPE_LOCAL);
    end else if (r.op == sdp_pkg::OP_CALL) begin
      fGp = !fa[sdp_pkg::ACC_S] || !fa[sdp_pkg::ACC_E] || (fa[6:5] > r.current_priv_level); // RULE16
    end else if (r.seg == sdp_pkg::SEG_CODE) begin
      fGp = !fa[sdp_pkg::ACC_S] || !fa[sdp_pkg::ACC_E]
            || (fa[sdp_pkg::ACC_CE] ? (r.current_priv_level < fa[6:5]) : (fa[6:5] != r.current_priv_level)); // RULE7
    end else if (r.seg == sdp_pkg::SEG_STACK) begin
      fGp = !fa[sdp_pkg::ACC_S] || fa[sdp_pkg::ACC_E] || !fa[sdp_pkg::ACC_WR]
            || (fa[6:5] != r.current_priv_level) || (r.sel[1:0] != r.current_priv_level);
    end else begin
      fGp = !fa[sdp_pkg::ACC_S]
            || (fa[sdp_pkg::ACC_E] && !fa[sdp_pkg::ACC_WR]) // RULE24
            || (!(fa[sdp_pkg::ACC_E] && fa[sdp_pkg::ACC_CE]) && (fa[6:5] < fEpl)); // RULE23 RULE15
    end
    if (!fa[sdp_pkg::ACC_S] && !sdp_pkg::SYS_TYPES[fa[3:0]]) begin
      fGp = 1'b1; // RULE11
    end
  end

  assign fFault = (r.op != sdp_pkg::OP_TEST) && (fGp || !fa[sdp_pkg::ACC_P]); // RULE2

  // writable registers
  assign wrOk = (r.awAddr == sdp_pkg::OFF_FLAGS) || (r.awAddr == sdp_pkg::OFF_SEL)
                || (r.awAddr == sdp_pkg::OFF_OFFSET) || (r.awAddr == sdp_pkg::OFF_GTBASE)
                || cmdFire;

  // read mux
  always_comb begin
    rdOk   = 1'b1;
    rdWord = 32'h0000_0000;
    case (axiIn.araddr)
      sdp_pkg::OFF_FLAGS:  rdWord = r.flags;
      sdp_pkg::OFF_SEL:    rdWord = {16'h0000, r.sel};
      sdp_pkg::OFF_OFFSET: rdWord = r.offset;
      sdp_pkg::OFF_GTBASE: rdWord = r.gtBase;
      sdp_pkg::OFF_STATUS: rdWord = {14'h0000, r.current_priv_level, r.vector, 6'h00, r.fault,
                                     r.st != sdp_pkg::ST_IDLE};
      sdp_pkg::OFF_PADDR:  rdWord = {8'h00, r.paddr};
      sdp_pkg::OFF_RESULT: rdWord = {16'h0000, r.result};
      sdp_pkg::OFF_LTBASE: rdWord = r.ltBase;
      sdp_pkg::OFF_DLO:    rdWord = r.segDesc[r.viewSeg][31:0];
      sdp_pkg::OFF_DHI:    rdWord = r.segDesc[r.viewSeg][63:32];
      default:             rdOk   = 1'b0;
    endcase
  end

  // next state
  always_comb begin
    n = r;
    n.busStart = 1'b0;
    if (r.bValid && axiIn.bready) begin
      n.bValid = 1'b0;
    end
    if (r.rValid && axiIn.rready) begin
      n.rValid = 1'b0;
    end
    if (axiIn.awvalid && axiOut.awready) begin
      n.awHeld = 1'b1;
      n.awAddr = axiIn.awaddr;
    end
    if (axiIn.wvalid && axiOut.wready) begin
      n.wHeld = 1'b1;
      n.wData = axiIn.wdata;
      n.wStrb = axiIn.wstrb;
    end
    if (axiIn.arvalid && axiOut.arready) begin
      n.rValid = 1'b1;
      n.rData  = rdWord;
      n.rResp  = rdOk ? sdp_pkg::RESP_OKAY : sdp_pkg::RESP_SLVERR;
    end
    if (r.awHeld && r.wHeld) begin
      n.awHeld = 1'b0;
      n.wHeld  = 1'b0;
      n.bValid = 1'b1;
      n.bResp  = wrOk ? sdp_pkg::RESP_OKAY : sdp_pkg::RESP_SLVERR;
      if (r.awAddr == sdp_pkg::OFF_FLAGS) begin
        n.flags = merge(r.flags, r.wData, r.wStrb);
        if (r.current_priv_level != 2'h0) begin
          n.flags[sdp_pkg::PPL_LO +: 2] = r.flags[sdp_pkg::PPL_LO +: 2]; // RULE20
        end
      end
      if (r.awAddr == sdp_pkg::OFF_SEL) begin
        n.sel = wMerged[15:0];
      end
      if (r.awAddr == sdp_pkg::OFF_OFFSET) begin
        n.offset = merge(r.offset, r.wData, r.wStrb);
      end
      if (r.awAddr == sdp_pkg::OFF_GTBASE) begin
        n.gtBase = merge(r.gtBase, r.wData, r.wStrb);
      end
    end
    if (cmdFire) begin
      n.op      = cmdOp;
      n.seg     = (cmdOp == sdp_pkg::OP_CALL) ? sdp_pkg::SEG_CODE : segIdx;
      n.viewSeg = n.seg;
      n.fault   = 1'b0;
      n.vector  = 8'h00;
      if (badSeg) begin
        n.fault  = 1'b1;
        n.vector = sdp_pkg::VEC_GP;
      end else begin
        unique case (cmdOp)
          sdp_pkg::OP_CHECK: begin
            n.fault  = cFault;
            n.vector = cFault ? cVec : 8'h00;
            if (!cFault) begin
              n.busStart = 1'b1; // RULE25
              n.busWrite = (cmdKind == sdp_pkg::KIND_WRITE);
              n.paddr    = cLin[23:0]; // RULE5
            end
          end
          sdp_pkg::OP_IO: begin
            if (cmdIo != sdp_pkg::IO_OTHER && r.current_priv_level > r.flags[sdp_pkg::PPL_LO +: 2]) begin
              n.fault  = 1'b1; // RULE21
              n.vector = sdp_pkg::VEC_GP;
            end
          end
          sdp_pkg::OP_ADJ: begin
            n.result = {r.sel[15:2], maxPl(r.sel[1:0], r.current_priv_level)}; // RULE19
          end
          sdp_pkg::OP_RET: begin
            n.current_priv_level = r.savedCpl; // RULE17
          end
          sdp_pkg::OP_LOAD: begin
            if (segIdx >= sdp_pkg::SEG_DATA && r.sel[15:2] == 14'h0000) begin
              n.segSel[segIdx]   = r.sel;
              n.segValid[segIdx] = 1'b0;
            end else begin
              n.st      = sdp_pkg::ST_FETCH; // RULE13
              n.memReq  = 1'b1;
              n.memWe   = 1'b0;
              n.memAddr = fAddr[23:0];
            end
          end
          sdp_pkg::OP_TEST, sdp_pkg::OP_CALL, sdp_pkg::OP_LDLOC: begin
            n.st      = sdp_pkg::ST_FETCH;
            n.memReq  = 1'b1;
            n.memWe   = 1'b0;
            n.memAddr = fAddr[23:0];
          end
        endcase
      end
    end
    unique case (r.st)
      sdp_pkg::ST_IDLE: begin
      end
      sdp_pkg::ST_FETCH: begin
        if (memIn.ack) begin
          n.memReq  = 1'b0;
          n.st      = sdp_pkg::ST_IDLE;
          n.memData = fd;
          n.memData[sdp_pkg::DESC_A] = 1'b1; // RULE8
          if (fFault) begin
            n.fault  = 1'b1;
            n.vector = fGp ? sdp_pkg::VEC_GP : sdp_pkg::VEC_NP;
          end else if (r.op == sdp_pkg::OP_LDLOC) begin
            n.ltBase  = {fd[63:56], fd[39:32], fd[31:16]}; // RULE11
            n.ltLimit = {fd[51:48], fd[15:0]};
          end else begin
            if (r.op != sdp_pkg::OP_TEST) begin
              n.segSel[r.seg]   = r.sel; // RULE13 RULE14
              n.segDesc[r.seg]  = n.memData;
              n.segValid[r.seg] = 1'b1;
            end else begin
              n.result = r.sel;
            end
            if (r.op == sdp_pkg::OP_CALL) begin
              n.savedCpl = r.current_priv_level;
              n.current_priv_level      = fa[6:5]; // RULE17 RULE3
            end
            if (!fa[sdp_pkg::ACC_A]) begin
              n.st     = sdp_pkg::ST_WBACK; // RULE8
              n.memReq = 1'b1;
              n.memWe  = 1'b1;
            end
          end
        end
      end
      sdp_pkg::ST_WBACK: begin
        if (memIn.ack) begin
          n.memReq = 1'b0;
          n.memWe  = 1'b0;
          n.st     = sdp_pkg::ST_IDLE;
        end
      end
      default: n.st = sdp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      r <= sdp_pkg::STATE_RST;
    end else begin
      r <= n;
    end
  end

  // outputs
  assign axiOut = '{awready: !r.awHeld && !r.bValid, wready: !r.wHeld && !r.bValid,
                    bvalid: r.bValid, bresp: r.bResp, arready: !r.rValid,
                    rvalid: r.rValid, rdata: r.rData, rresp: r.rResp};
  assign memOut = '{req: r.memReq, we: r.memWe, addr: r.memAddr, wdata: r.memData};
  assign busOut = '{start: r.busStart, write: r.busWrite, addr: r.paddr};

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  a_bus_no_fault : assert property (r.busStart |-> !r.fault) // RULE25
    else $error("bus cycle started on a faulted access");
  a_limit_abort : assert property (cmdFire && cmdOp == sdp_pkg::OP_CHECK && !cInLim // RULE6
    |=> !r.busStart && r.fault && r.vector != 8'h00)
    else $error("out of limit access not aborted");
  a_phys_trunc : assert property (cmdFire && cmdOp == sdp_pkg::OP_CHECK && !cFault // RULE5
    && !badSeg |=> r.busStart && r.paddr == $past(cLin[23:0]))
    else $error("physical address not truncated linear address");
  a_not_present : assert property (cmdFire && cmdOp == sdp_pkg::OP_CHECK && !badSeg // RULE2
    && r.segValid[segIdx] && !ca[sdp_pkg::ACC_P] |=> r.fault && r.vector == 8'h0b)
    else $error("absent segment did not raise vector 11");
  a_port_fault : assert property (cmdFire && cmdOp == sdp_pkg::OP_IO && !badSeg // RULE21
    && cmdIo != sdp_pkg::IO_OTHER && r.current_priv_level > r.flags[14:13]
    |=> r.fault && r.vector == 8'h0d)
    else $error("port instruction above port level not faulted");
  a_cache_stable : assert property (r.st != sdp_pkg::ST_FETCH |=> $stable(r.segDesc)) // RULE14
    else $error("descriptor cache changed without a segment load");
  a_cpl_gate : assert property ($changed(r.current_priv_level) // RULE17
    |-> r.op == sdp_pkg::OP_CALL || r.op == sdp_pkg::OP_RET)
    else $error("current level changed outside gate call or return");
  a_port_level : assert property ($changed(r.flags[14:13]) |-> $past(r.current_priv_level) == 2'h0) // RULE20
    else $error("port level changed while not at level 0");
  a_accessed_set : assert property (r.st == sdp_pkg::ST_FETCH && memIn.ack && !fFault // RULE8
    && (r.op == sdp_pkg::OP_LOAD || r.op == sdp_pkg::OP_TEST) && !fa[0]
    |=> r.memWe && r.memReq && r.memData[40])
    else $error("accessed bit not written back");
  a_adjust_rpl : assert property (cmdFire && cmdOp == sdp_pkg::OP_ADJ && !badSeg // RULE19
    |=> r.result[1:0] >= $past(r.current_priv_level) && r.result[15:2] == $past(r.sel[15:2]))
    else $error("adjusted requestor field below current level");

endmodule : sdp_segment_protection

// >>> design/sdp_pkg.sv
// constants, carrier types and state layout of the segment protection unit
package sdp_pkg;
  localparam logic [7:0] OFF_FLAGS  = 8'h00;
  localparam logic [7:0] OFF_SEL    = 8'h04;
  localparam logic [7:0] OFF_OFFSET = 8'h08;
  localparam logic [7:0] OFF_GTBASE = 8'h0c;
  localparam logic [7:0] OFF_CMD    = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_PADDR  = 8'h18;
  localparam logic [7:0] OFF_RESULT = 8'h1c;
  localparam logic [7:0] OFF_LTBASE = 8'h20;
  localparam logic [7:0] OFF_DLO    = 8'h24;
  localparam logic [7:0] OFF_DHI    = 8'h28;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] VEC_NP = 8'h0b;
  localparam logic [7:0] VEC_GP = 8'h0d;
  localparam int ACC_P  = 7;
  localparam int ACC_S  = 4;
  localparam int ACC_E  = 3;
  localparam int ACC_CE = 2;
  localparam int ACC_WR = 1;
  localparam int ACC_A  = 0;
  localparam int ACC_LO = 40;
  localparam int DESC_A = 40;
  localparam int PPL_LO = 13;
  localparam int CMD_OP_LO   = 0;
  localparam int CMD_SEG_LO  = 4;
  localparam int CMD_KIND_LO = 8;
  localparam int CMD_IO_LO   = 12;
  localparam logic [1:0]  KIND_WRITE = 2'h1;
  localparam logic [1:0]  KIND_EXEC  = 2'h2;
  localparam logic [2:0]  IO_OTHER   = 3'h7;
  localparam logic [2:0]  SEG_CODE   = 3'h0;
  localparam logic [2:0]  SEG_STACK  = 3'h1;
  localparam logic [2:0]  SEG_DATA   = 3'h2;
  localparam logic [2:0]  NUM_SEG    = 3'h6;
  localparam logic [3:0]  TYPE_LOCAL = 4'h2;
  localparam logic [15:0] SYS_TYPES  = 16'hda24;
  localparam logic [11:0] PAGE_FILL  = 12'hfff;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_WBACK = 2'b10
  } sdp_fsm_t;

  typedef enum logic [2:0] {
    OP_LOAD  = 3'b000,
    OP_CHECK = 3'b001,
    OP_IO    = 3'b010,
    OP_ADJ   = 3'b011,
    OP_TEST  = 3'b100,
    OP_CALL  = 3'b101,
    OP_RET   = 3'b110,
    OP_LDLOC = 3'b111
  } sdp_op_t;

  typedef struct packed {
    logic awvalid; logic [7:0] awaddr; logic wvalid; logic [31:0] wdata;
    logic [3:0] wstrb; logic bready; logic arvalid; logic [7:0] araddr;
    logic rready;
  } sdp_axil_in_t;

  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } sdp_axil_out_t;

  typedef struct packed {
    logic req; logic we; logic [23:0] addr; logic [63:0] wdata;
  } sdp_mem_out_t;

  typedef struct packed {logic ack; logic [63:0] rdata;} sdp_mem_in_t;

  typedef struct packed {logic start; logic write; logic [23:0] addr;} sdp_bus_out_t;

  typedef struct packed {
    sdp_fsm_t st; sdp_op_t op; logic [2:0] seg; logic [2:0] viewSeg;
    logic awHeld; logic [7:0] awAddr; logic wHeld; logic [31:0] wData;
    logic [3:0] wStrb; logic bValid; logic [1:0] bResp;
    logic rValid; logic [31:0] rData; logic [1:0] rResp;
    logic [31:0] flags; logic [15:0] sel; logic [31:0] offset;
    logic [31:0] gtBase; logic [31:0] ltBase; logic [19:0] ltLimit;
    logic [1:0] current_priv_level; logic [1:0] savedCpl;
    logic memReq; logic memWe; logic [23:0] memAddr; logic [63:0] memData;
    logic [5:0][15:0] segSel; logic [5:0][63:0] segDesc; logic [5:0] segValid;
    logic fault; logic [7:0] vector; logic [15:0] result;
    logic [23:0] paddr; logic busStart; logic busWrite;
  } sdp_state_t;

  localparam sdp_state_t STATE_RST = '0;
endpackage : sdp_pkg

// >>> verif/sdp_desc_mem.sv
// descriptor table memory model answering fetch and write-back requests
module sdp_desc_mem (
  // clock
  input  wire logic                  mclk,
  // descriptor port
  input  wire sdp_pkg::sdp_mem_out_t memOut,
  output      sdp_pkg::sdp_mem_in_t  memIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] tbl [0:31];
  logic [23:0] lastAddr;
  int          dly = 0;
  int          cnt = 0;
  initial memIn = '0;
  always @(posedge mclk) begin
    memIn.ack <= 1'b0;
    memIn.rdata <= ~memIn.rdata;
    if (memOut.req && !memIn.ack) begin
      if (cnt >= dly) begin
        cnt = 0;
        memIn.ack <= 1'b1;
        lastAddr <= memOut.addr;
        if (memOut.we) tbl[memOut.addr[7:3]] <= memOut.wdata;
        else memIn.rdata <= tbl[memOut.addr[7:3]];
      end else cnt++;
    end
  end
endmodule : sdp_desc_mem

// >>> verif/tb.sv
// self-checking bench for the segment protection unit
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   mclk;
  logic                   srst;
  sdp_pkg::sdp_axil_in_t  axiIn;
  sdp_pkg::sdp_axil_out_t axiOut;
  sdp_pkg::sdp_mem_out_t  memOut;
  sdp_pkg::sdp_mem_in_t   memIn;
  sdp_pkg::sdp_bus_out_t  busOut;
  logic [31:0]            d;
  logic [31:0]            stat;
  logic [1:0]             r;
  logic [23:0]            lastBus;
  logic [63:0]            e;
  int                     starts = 0;
  int                     bad_count = 0;
  int                     samples_checked = 0;

  sdp_segment_protection DUT (.mclk(mclk), .srst(srst), .axiIn(axiIn), .axiOut(axiOut),
    .memOut(memOut), .memIn(memIn), .busOut(busOut));
  sdp_desc_mem mem (.mclk(mclk), .memOut(memOut), .memIn(memIn));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (busOut.start === 1'b1) begin
      starts++;
      lastBus = busOut.addr;
    end
  end

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    axiIn.awvalid <= 1'b1; axiIn.awaddr <= a; axiIn.wvalid <= 1'b1;
    axiIn.wdata <= v; axiIn.wstrb <= 4'hf; axiIn.bready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (axiIn.awvalid && axiOut.awready) axiIn.awvalid <= 1'b0;
      if (axiIn.wvalid && axiOut.wready) axiIn.wvalid <= 1'b0;
      if (axiIn.bready && axiOut.bvalid) break;
    end
    r = axiOut.bresp;
    axiIn.bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    axiIn.arvalid <= 1'b1; axiIn.araddr <= a; axiIn.rready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (axiIn.arvalid && axiOut.arready) axiIn.arvalid <= 1'b0;
      if (axiIn.rready && axiOut.rvalid) break;
    end
    d = axiOut.rdata;
    r = axiOut.rresp;
    axiIn.rready <= 1'b0;
  endtask : rd
  task automatic cmd(input logic [2:0] op, input logic [2:0] seg, input logic [1:0] kind,
                     input logic [2:0] io);
    int n;
    wr(sdp_pkg::OFF_CMD, {17'h0, io, 2'h0, kind, 1'b0, seg, 1'b0, op});
    n = 0;
    do begin
      rd(sdp_pkg::OFF_STATUS);
      stat = d;
      n++;
    end while (stat[0] !== 1'b0 && n < 100);
    chk("cmd done", stat[0], 1'b0);
  endtask : cmd
  function automatic logic [63:0] dsc(input logic [31:0] b, input logic [19:0] l,
                                      input logic [7:0] a, input logic g);
    return {b[31:24], g, 3'h4, l[19:16], a, b[23:16], b[15:0], l[15:0]};
  endfunction : dsc
  task automatic ld(input logic [4:0] idx, input logic [63:0] ds, input logic [1:0] requestor_priv_field,
                    input logic [2:0] seg, input logic [7:0] vec);
    mem.tbl[idx] = ds;
    wr(sdp_pkg::OFF_SEL, {24'h0, idx, 1'b0, requestor_priv_field});
    cmd(sdp_pkg::OP_LOAD, seg, 2'h0, sdp_pkg::IO_OTHER);
    chk("load vector", stat[15:8], vec);
  endtask : ld
  task automatic acc(input logic [2:0] seg, input logic [31:0] off, input logic [1:0] kind,
                     input logic [7:0] vec);
    int s0;
    wr(sdp_pkg::OFF_OFFSET, off);
    s0 = starts;
    cmd(sdp_pkg::OP_CHECK, seg, kind, sdp_pkg::IO_OTHER);
    chk("check vector", stat[15:8], vec);
    chk("fault flag", stat[1], vec != 8'h00);
    chk("bus starts", starts - s0, vec == 8'h00);
    if (vec == 8'h00) chk("bus write", busOut.write, kind == sdp_pkg::KIND_WRITE);
  endtask : acc

  task automatic t_reset;
    rd(sdp_pkg::OFF_STATUS);
    chk("status", d, 0);
    rd(8'h40);
    chk("unmapped rresp", r, sdp_pkg::RESP_SLVERR);
    chk("unmapped rdata", d, 0);
    wr(sdp_pkg::OFF_RESULT, 32'h0000_0001);
    chk("read-only bresp", r, sdp_pkg::RESP_SLVERR);
    $display("test reset done");
  endtask : t_reset
  task automatic t_data;
    wr(sdp_pkg::OFF_GTBASE, 32'hff00_1000);
    e = dsc(32'hab12_3400, 20'h0_0010, 8'h92, 1'b0);
    ld(5'h01, e, 2'h0, sdp_pkg::SEG_DATA, 8'h00);
    chk("fetch addr", mem.lastAddr, 24'h00_1008);
    chk("accessed bit", mem.tbl[1][sdp_pkg::DESC_A], 1'b1);
    acc(sdp_pkg::SEG_DATA, 32'h0000_0010, 2'h0, 8'h00);
    chk("paddr", lastBus, 24'h12_3410);
    acc(sdp_pkg::SEG_DATA, 32'h0000_0011, 2'h0, sdp_pkg::VEC_GP);
    acc(sdp_pkg::SEG_DATA, 32'h0000_0004, sdp_pkg::KIND_WRITE, 8'h00);
    e[sdp_pkg::DESC_A] = 1'b1;
    rd(sdp_pkg::OFF_DHI);
    chk("cache high", d, e[63:32]);
    $display("test data done");
  endtask : t_data
  task automatic t_limits;
    mem.dly = 5;
    ld(5'h02, dsc(0, 20'h0_0010, 8'h96, 1'b0), 2'h0, 3'h3, 8'h00);
    acc(3'h3, 32'h0000_0010, 2'h0, sdp_pkg::VEC_GP);
    acc(3'h3, 32'h0000_0011, 2'h0, 8'h00);
    ld(5'h03, dsc(0, 20'h0_0001, 8'h90, 1'b1), 2'h0, 3'h4, 8'h00);
    acc(3'h4, 32'h0000_1fff, 2'h0, 8'h00);
    acc(3'h4, 32'h0000_2000, 2'h0, sdp_pkg::VEC_GP);
    acc(3'h4, 32'h0000_0000, sdp_pkg::KIND_WRITE, sdp_pkg::VEC_GP);
    mem.dly = 0;
    $display("test limits done");
  endtask : t_limits
  task automatic t_priv;
    ld(5'h04, dsc(0, 20'hf_ffff, 8'h12, 1'b0), 2'h0, 3'h5, sdp_pkg::VEC_NP);
    ld(5'h05, dsc(0, 20'hf_ffff, 8'hb2, 1'b0), 2'h3, 3'h5, sdp_pkg::VEC_GP);
    ld(5'h05, dsc(0, 20'hf_ffff, 8'hb2, 1'b0), 2'h1, 3'h5, 8'h00);
    ld(5'h06, dsc(0, 20'hf_ffff, 8'h82, 1'b0), 2'h0, 3'h2, sdp_pkg::VEC_GP);
    ld(5'h07, dsc(0, 20'hf_ffff, 8'h98, 1'b0), 2'h0, 3'h2, sdp_pkg::VEC_GP);
    ld(5'h07, dsc(0, 20'hf_ffff, 8'h9a, 1'b0), 2'h0, 3'h2, 8'h00);
    acc(3'h2, 32'h0000_0000, 2'h0, 8'h00);
    acc(3'h2, 32'h0000_0000, sdp_pkg::KIND_WRITE, sdp_pkg::VEC_GP);
    acc(3'h2, 32'h0000_0000, sdp_pkg::KIND_EXEC, 8'h00);
    $display("test privilege done");
  endtask : t_priv
  task automatic t_cache;
    ld(5'h01, dsc(32'h0000_5000, 20'hf_ffff, 8'h92, 1'b0), 2'h0, 3'h5, 8'h00);
    mem.tbl[1] = dsc(32'h0000_7000, 20'hf_ffff, 8'h92, 1'b0);
    acc(3'h5, 32'h0000_0020, 2'h0, 8'h00);
    chk("stale base", lastBus, 24'h00_5020);
    ld(5'h01, dsc(32'h0000_7000, 20'hf_ffff, 8'h92, 1'b0), 2'h0, 3'h5, 8'h00);
    acc(3'h5, 32'h0000_0020, 2'h0, 8'h00);
    chk("reloaded base", lastBus, 24'h00_7020);
    $display("test cache done");
  endtask : t_cache
  task automatic t_misc;
    mem.tbl[1][sdp_pkg::DESC_A] = 1'b0;
    wr(sdp_pkg::OFF_SEL, 32'h0000_0009);
    cmd(sdp_pkg::OP_TEST, 3'h0, 2'h0, sdp_pkg::IO_OTHER);
    rd(sdp_pkg::OFF_RESULT);
    chk("test result", d[15:0], 16'h0009);
    chk("test accessed", mem.tbl[1][sdp_pkg::DESC_A], 1'b1);
    cmd(sdp_pkg::OP_ADJ, 3'h0, 2'h0, sdp_pkg::IO_OTHER);
    rd(sdp_pkg::OFF_RESULT);
    chk("adjusted", d[15:0], 16'h0009);
    mem.tbl[6] = dsc(32'h1234_5678, 20'h0_00ff, 8'h82, 1'b0);
    wr(sdp_pkg::OFF_SEL, 32'h0000_0030);
    cmd(sdp_pkg::OP_LDLOC, 3'h0, 2'h0, sdp_pkg::IO_OTHER);
    rd(sdp_pkg::OFF_LTBASE);
    chk("local base", d, 32'h1234_5678);
    mem.tbl[8] = dsc(0, 20'hf_ffff, 8'hba, 1'b0);
    wr(sdp_pkg::OFF_SEL, 32'h0000_0040);
    cmd(sdp_pkg::OP_CALL, 3'h0, 2'h0, sdp_pkg::IO_OTHER);
    chk("call outward", stat[15:8], sdp_pkg::VEC_GP);
    wr(sdp_pkg::OFF_SEL, 32'h0000_0038);
    cmd(sdp_pkg::OP_CALL, 3'h0, 2'h0, sdp_pkg::IO_OTHER);
    chk("call gate", stat[17:8], 10'h000);
    cmd(sdp_pkg::OP_RET, 3'h0, 2'h0, sdp_pkg::IO_OTHER);
    chk("return", stat[17:8], 10'h000);
    wr(sdp_pkg::OFF_FLAGS, 32'h0000_6000);
    rd(sdp_pkg::OFF_FLAGS);
    chk("port level", d[14:13], 2'h3);
    for (int i = 0; i < 7; i++) begin
      cmd(sdp_pkg::OP_IO, 3'h0, 2'h0, 3'(i));
      chk("io vector", stat[15:8], 8'h00);
    end
    $display("test misc done");
  endtask : t_misc

  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    results();
  end
  initial begin
    axiIn = '0;
    srst = 1'b1;
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    t_reset();
    t_data();
    t_limits();
    t_priv();
    t_cache();
    t_misc();
    results();
  end
endmodule : tb
